// ### inc/fax_demod_consts.vh
`ifndef FAX_DEMOD_CONSTS_VH
`define FAX_DEMOD_CONSTS_VH

// Clock rate and state timeout
`define CLK_MHZ 125
`define STATE_TMO_MS 1000
`define STATE_TMO_CYC ((`STATE_TMO_MS) * 1000 * (`CLK_MHZ))

// Partial-page retry limit
`define RETRY_LIMIT 2'h3
`define RETRY_RESET 2'h0

// Register offsets (byte addresses)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4

// Control register fields and reset value
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 1'h1

// Status register field positions
`define STAT_STATE_LSB 0
`define STAT_COUNT_LSB 10
`define STAT_RATE_LSB 12
`define STAT_KIND_LSB 16
`define STAT_DEMUX_BIT 20
`define STAT_MUX_BIT 21

// T.30 message codes on msg_code
`define MSG_DIS 6'h01
`define MSG_DCS 6'h02
`define MSG_NSS 6'h03
`define MSG_NSC 6'h04
`define MSG_DTC 6'h05
`define MSG_CFR 6'h06
`define MSG_CRP 6'h07
`define MSG_FTT 6'h08
`define MSG_DCN 6'h09
`define MSG_MCF 6'h0a
`define MSG_RTP 6'h0b
`define MSG_RTN 6'h0c
`define MSG_PPR 6'h0d
`define MSG_PIN 6'h0e
`define MSG_PIP 6'h0f
`define MSG_EOP 6'h10
`define MSG_EOM 6'h11
`define MSG_MPS 6'h12
`define MSG_PRI_EOP 6'h13
`define MSG_PRI_EOM 6'h14
`define MSG_PRI_MPS 6'h15
`define MSG_PPS_EOP 6'h16
`define MSG_PPS_EOM 6'h17
`define MSG_PPS_MPS 6'h18
`define MSG_PPS_PRI_EOP 6'h19
`define MSG_PPS_PRI_EOM 6'h1a
`define MSG_PPS_PRI_MPS 6'h1b
`define MSG_PPS_NULL 6'h1c

`endif

// ### hw/fax_demod_endpoint_call_fsm.v
`include "fax_demod_consts.vh"

// Operation
// - Compatible DCS/NSS in local setup: store rate/kind, demod path, begin, clear count.
// - Incompatible DCS/NSS in local setup: release everything, back to idle.
// - NSC or DTC from channel side in local setup: take remodulating role.
// - V.21 arriving during training or page: packet voice, halt request, release, idle.
// - Stop confirm: packet voice, then confirm-to-receive or post-page command.
// - Abandon confirm during training or page: packet voice, release, idle.
// - DCS or NSS from channel side awaiting confirm: packet voice, release, idle.
// - CFR from packet side: demod path, begin with stored values, await page end.
// - CRP, FTT, NSC or DTC from packet side: back to local setup.
// - Next channel-side message latched as post-page command; then await response.
// - EOP-class command answered by MCF: release resources, return to idle.
// - EOM-class with MCF, or EOM/PRI-EOM with RTP/RTN: back to local setup.
// - MPS-class command answered by MCF: multipage, retry count cleared.
// - PPR with retry count below 3: multipage, retry count incremented.
// - Multipage: demod path, begin with stored values, await page end.
// - PPR with retry count at 3: clear count, await continue or retransmission end.
// - MPS, EOP, PRI-MPS or PRI-EOP with RTN/RTP: back to local setup.
// - PIN or PIP response: enter await-command state.
// - Timed states expire without a message: release resources, return to idle.
// - Final DCN or DIS from either side in timed states: release, idle.
// - Idle, enabled, packet voice, packet-side DIS and free demodulator: allocate, local setup.
module fax_demod_endpoint_call_fsm #(
  parameter [31:0] local_setup_cycles = `STATE_TMO_CYC,
  parameter [31:0] remote_setup_cycles = `STATE_TMO_CYC,
  parameter [31:0] confirm_cycles = `STATE_TMO_CYC,
  parameter [31:0] post_cmd_cycles = `STATE_TMO_CYC,
  parameter [31:0] post_resp_cycles = `STATE_TMO_CYC,
  parameter [31:0] command_cycles = `STATE_TMO_CYC,
  parameter [31:0] retx_cycles = `STATE_TMO_CYC
) (
  input wire mclk,
  input wire nrst,
  input wire msg_valid,
  input wire [5:0] msg_code,
  input wire msg_final,
  input wire msg_from_pkt,
  input wire [3:0] msg_rate,
  input wire [3:0] msg_kind,
  input wire rate_kind_ok,
  input wire demod_avail,
  input wire v21_arriving_chan,
  input wire v21_arriving_pkt,
  input wire ml_stop_confirm,
  input wire modlayer_abandon_confirm,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg demod_remod_path,
  output reg far_demod_remod_path,
  output wire packet_voice_path,
  output reg modlayer_begin_request,
  output reg modlayer_halt_request,
  output wire [3:0] begin_rate,
  output wire [3:0] begin_kind,
  output reg resource_alloc,
  output reg resource_release,
  output reg [3:0] stored_modem_rate,
  output reg [3:0] stored_modem_kind,
  output reg [1:0] partial_page_retry_count,
  output reg [9:0] call_state
);

  localparam [9:0] S_IDLE = 10'h001;
  localparam [9:0] S_LSET = 10'h002;
  localparam [9:0] S_RSET = 10'h004;
  localparam [9:0] S_TRAIN = 10'h008;
  localparam [9:0] S_CFR = 10'h010;
  localparam [9:0] S_PAGE = 10'h020;
  localparam [9:0] S_PCMD = 10'h040;
  localparam [9:0] S_PRSP = 10'h080;
  localparam [9:0] S_CMD = 10'h100;
  localparam [9:0] S_CTC = 10'h200;

  reg [9:0] state_d;
  reg [5:0] cmd_q;
  reg [5:0] cmd_d;
  reg [31:0] tmr_q;
  reg [31:0] tmr_d;
  reg enable_q;
  reg [3:0] rate_d;
  reg [3:0] kind_d;
  reg [1:0] cnt_d;
  reg demux_d;
  reg mux_d;
  reg begin_d;
  reg halt_d;
  reg alloc_d;
  reg release_d;
  reg kill;
  reg multipage;
  wire expire;
  wire chan_msg;
  wire pkt_msg;

  function timed;
    input [9:0] s;
    begin
      timed = !(s == S_IDLE || s == S_TRAIN || s == S_PAGE);
    end
  endfunction

  function [31:0] tmo;
    input [9:0] s;
    begin
      case (s)
        S_LSET: tmo = local_setup_cycles;
        S_RSET: tmo = remote_setup_cycles;
        S_CFR: tmo = confirm_cycles;
        S_PCMD: tmo = post_cmd_cycles;
        S_PRSP: tmo = post_resp_cycles;
        S_CMD: tmo = command_cycles;
        S_CTC: tmo = retx_cycles;
        default: tmo = 32'h0;
      endcase
    end
  endfunction

  function is_eop;
    input [5:0] c;
    begin
      is_eop = c == `MSG_EOP || c == `MSG_PRI_EOP || c == `MSG_PPS_EOP || c == `MSG_PPS_PRI_EOP;
    end
  endfunction

  function is_eom;
    input [5:0] c;
    begin
      is_eom = c == `MSG_EOM || c == `MSG_PRI_EOM || c == `MSG_PPS_EOM || c == `MSG_PPS_PRI_EOM;
    end
  endfunction

  function is_mps;
    input [5:0] c;
    begin
      is_mps = c == `MSG_MPS || c == `MSG_PRI_MPS || c == `MSG_PPS_MPS ||
               c == `MSG_PPS_PRI_MPS || c == `MSG_PPS_NULL;
    end
  endfunction

  // Setup and role-swap codes are decoded in two states
  function is_setup;
    input [5:0] c;
    begin
      is_setup = c == `MSG_DCS || c == `MSG_NSS;
    end
  endfunction

  function is_swap;
    input [5:0] c;
    begin
      is_swap = c == `MSG_NSC || c == `MSG_DTC;
    end
  endfunction

  // Strobes are single-cycle by contract with the demodulators
  assign chan_msg = msg_valid && !msg_from_pkt;
  assign pkt_msg = msg_valid && msg_from_pkt;

  // A message in the same cycle as the last count wins over the timeout
  assign expire = timed(call_state) && tmr_q == 32'h0 && !msg_valid;

  assign packet_voice_path = !demod_remod_path && !far_demod_remod_path;
  assign begin_rate = stored_modem_rate;
  assign begin_kind = stored_modem_kind;

  always @* begin
    state_d = call_state;
    cmd_d = cmd_q;
    rate_d = stored_modem_rate;
    kind_d = stored_modem_kind;
    cnt_d = partial_page_retry_count;
    demux_d = demod_remod_path;
    mux_d = far_demod_remod_path;
    begin_d = 1'b0;
    halt_d = 1'b0;
    alloc_d = 1'b0;
    release_d = 1'b0;
    kill = 1'b0;
    multipage = 1'b0;
    case (call_state)
      S_IDLE: begin
        if (pkt_msg && msg_code == `MSG_DIS && demod_avail && enable_q && packet_voice_path) begin
          alloc_d = 1'b1;
          state_d = S_LSET;
        end
      end
      S_LSET: begin
        if (chan_msg && is_setup(msg_code)) begin
          if (rate_kind_ok) begin
            rate_d = msg_rate;
            kind_d = msg_kind;
            demux_d = 1'b1;
            begin_d = 1'b1;
            cnt_d = `RETRY_RESET;
            state_d = S_TRAIN;
          end else begin
            kill = 1'b1;
          end
        end else if (chan_msg && is_swap(msg_code)) begin
          state_d = S_RSET;
        end
      end
      S_TRAIN, S_PAGE: begin
        // Abandon outranks stop, which outranks a fresh V.21 burst
        if (modlayer_abandon_confirm) begin
          kill = 1'b1;
        end else if (ml_stop_confirm) begin
          demux_d = 1'b0;
          mux_d = 1'b0;
          state_d = (call_state == S_TRAIN) ? S_CFR : S_PCMD;
        end else if (v21_arriving_chan || v21_arriving_pkt) begin
          halt_d = 1'b1;
          kill = 1'b1;
        end
      end
      S_CFR: begin
        if (chan_msg && is_setup(msg_code)) begin
          kill = 1'b1;
        end else if (pkt_msg && msg_code == `MSG_CFR) begin
          demux_d = 1'b1;
          begin_d = 1'b1;
          state_d = S_PAGE;
        end else if (pkt_msg && (msg_code == `MSG_CRP || msg_code == `MSG_FTT || is_swap(msg_code))) begin
          state_d = S_LSET;
        end
      end
      S_PCMD: begin
        if (chan_msg) begin
          cmd_d = msg_code;
          state_d = S_PRSP;
        end
      end
      S_PRSP: begin
        if (pkt_msg) begin
          case (msg_code)
            `MSG_PPR: begin
              if (partial_page_retry_count < `RETRY_LIMIT) begin
                cnt_d = partial_page_retry_count + 2'h1;
                multipage = 1'b1;
              end else begin
                cnt_d = `RETRY_RESET;
                state_d = S_CTC;
              end
            end
            `MSG_PIN, `MSG_PIP: begin
              state_d = S_CMD;
            end
            `MSG_MCF: begin
              if (is_eop(cmd_q)) begin
                kill = 1'b1;
              end else if (is_eom(cmd_q)) begin
                state_d = S_LSET;
              end else if (is_mps(cmd_q)) begin
                cnt_d = `RETRY_RESET;
                multipage = 1'b1;
              end
            end
            `MSG_RTP, `MSG_RTN: begin
              if (cmd_q == `MSG_EOM || cmd_q == `MSG_PRI_EOM) begin
                state_d = S_LSET;
              end else if (cmd_q == `MSG_MPS || cmd_q == `MSG_EOP ||
                           cmd_q == `MSG_PRI_MPS || cmd_q == `MSG_PRI_EOP) begin
                state_d = S_LSET;
              end
            end
            default: begin
              state_d = call_state;
            end
          endcase
        end
      end
      S_RSET, S_CMD, S_CTC: begin
        // Only the timeout and disconnect handling below act here
        state_d = call_state;
      end
      default: begin
        state_d = S_IDLE;
        kill = 1'b1;
      end
    endcase
    if (multipage) begin
      demux_d = 1'b1;
      begin_d = 1'b1;
      state_d = S_PAGE;
    end
    if (timed(call_state)) begin
      if (msg_valid && msg_final && (msg_code == `MSG_DCN || msg_code == `MSG_DIS)) begin
        kill = 1'b1;
      end
      if (expire) begin
        kill = 1'b1;
      end
    end
    if (kill) begin
      state_d = S_IDLE;
      demux_d = 1'b0;
      mux_d = 1'b0;
      begin_d = 1'b0;
      release_d = 1'b1;
    end
  end

  // Timer reloads on entry and on every message, so it only fires on silence
  always @* begin
    if (state_d != call_state || (msg_valid && timed(call_state))) begin
      tmr_d = tmo(state_d);
    end else if (tmr_q != 32'h0) begin
      tmr_d = tmr_q - 32'h1;
    end else begin
      tmr_d = tmr_q;
    end
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      call_state <= S_IDLE;
      cmd_q <= 6'h00;
      tmr_q <= 32'h0;
      stored_modem_rate <= 4'h0;
      stored_modem_kind <= 4'h0;
      partial_page_retry_count <= `RETRY_RESET;
      demod_remod_path <= 1'b0;
      far_demod_remod_path <= 1'b0;
      modlayer_begin_request <= 1'b0;
      modlayer_halt_request <= 1'b0;
      resource_alloc <= 1'b0;
      resource_release <= 1'b0;
    end else begin
      call_state <= state_d;
      cmd_q <= cmd_d;
      tmr_q <= tmr_d;
      stored_modem_rate <= rate_d;
      stored_modem_kind <= kind_d;
      partial_page_retry_count <= cnt_d;
      demod_remod_path <= demux_d;
      far_demod_remod_path <= mux_d;
      modlayer_begin_request <= begin_d;
      modlayer_halt_request <= halt_d;
      resource_alloc <= alloc_d;
      resource_release <= release_d;
    end
  end

  // Register port: control steers idle acceptance, status shows live state
  always @(posedge mclk) begin
    if (!nrst) begin
      enable_q <= `CTRL_RESET;
      reg_rdata <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == `REG_CTRL) begin
        enable_q <= reg_wdata[`CTRL_ENABLE_BIT];
      end
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `REG_CTRL: begin
            reg_rdata[`CTRL_ENABLE_BIT] <= enable_q;
          end
          `REG_STATUS: begin
            reg_rdata[`STAT_STATE_LSB +: 10] <= call_state;
            reg_rdata[`STAT_COUNT_LSB +: 2] <= partial_page_retry_count;
            reg_rdata[`STAT_RATE_LSB +: 4] <= stored_modem_rate;
            reg_rdata[`STAT_KIND_LSB +: 4] <= stored_modem_kind;
            reg_rdata[`STAT_DEMUX_BIT] <= demod_remod_path;
            reg_rdata[`STAT_MUX_BIT] <= far_demod_remod_path;
          end
          default: begin
            reg_rdata <= 32'h0;
          end
        endcase
      end
    end
  end

endmodule

// ### verification/fax_fsm_assertions.sv
`include "fax_demod_consts.vh"
module fax_fsm_chk (
  input wire mclk,
  input wire nrst,
  input wire msg_valid,
  input wire [5:0] msg_code,
  input wire msg_final,
  input wire msg_from_pkt,
  input wire [3:0] msg_rate,
  input wire rate_kind_ok,
  input wire v21_arriving_chan,
  input wire v21_arriving_pkt,
  input wire ml_stop_confirm,
  input wire modlayer_abandon_confirm,
  input wire demod_remod_path,
  input wire packet_voice_path,
  input wire modlayer_begin_request,
  input wire modlayer_halt_request,
  input wire [3:0] begin_rate,
  input wire resource_release,
  input wire [3:0] stored_modem_rate,
  input wire [1:0] partial_page_retry_count,
  input wire [9:0] call_state
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_setup_msg;
    call_state == 10'h002 && msg_valid && !msg_from_pkt && (msg_code == `MSG_DCS || msg_code == `MSG_NSS);
  endsequence
  sequence s_resp(logic [5:0] c);
    call_state == 10'h080 && msg_valid && msg_from_pkt && msg_code == c;
  endsequence
  // Abort outranks stop, stop outranks an arriving V.21 signal
  wire pg = call_state == 10'h008 || call_state == 10'h020;
  a_setup_begin: assert property (s_setup_msg ##0 rate_kind_ok |=>
    call_state == 10'h008 && demod_remod_path && modlayer_begin_request && partial_page_retry_count == 2'h0
    && stored_modem_rate == $past(msg_rate)) else $error("setup accept wrong");
  a_setup_reject: assert property (s_setup_msg ##0 !rate_kind_ok |=> call_state == 10'h001 && resource_release)
    else $error("setup reject wrong");
  a_role_swap: assert property (call_state == 10'h002 && msg_valid && !msg_from_pkt && !msg_final &&
    (msg_code == `MSG_NSC || msg_code == `MSG_DTC) |=> call_state == 10'h004) else $error("role swap wrong");
  a_arrive_halt: assert property (pg && (v21_arriving_chan || v21_arriving_pkt) && !ml_stop_confirm &&
    !modlayer_abandon_confirm |=> call_state == 10'h001 && modlayer_halt_request && packet_voice_path)
    else $error("arrival halt wrong");
  a_stop_move: assert property (call_state == 10'h008 && ml_stop_confirm && !modlayer_abandon_confirm |=>
    call_state == 10'h010 && packet_voice_path) else $error("stop confirm wrong");
  a_abort_idle: assert property (pg && modlayer_abandon_confirm |=>
    call_state == 10'h001 && packet_voice_path && resource_release) else $error("abort wrong");
  a_cfr_begin: assert property (call_state == 10'h010 && msg_valid && msg_from_pkt && msg_code == `MSG_CFR |=>
    call_state == 10'h020 && modlayer_begin_request && begin_rate == stored_modem_rate) else $error("cfr wrong");
  a_ppr_limit: assert property (s_resp(`MSG_PPR) ##0 partial_page_retry_count == 2'h3 |=>
    call_state == 10'h200 && partial_page_retry_count == 2'h0) else $error("ppr limit wrong");
  a_pin_cmd: assert property (s_resp(`MSG_PIN) or s_resp(`MSG_PIP) |=> call_state == 10'h100)
    else $error("interrupt response wrong");
  a_final_drop: assert property ((call_state & 10'h3d6) != 10'h0 && msg_valid && msg_final &&
    (msg_code == `MSG_DCN || msg_code == `MSG_DIS) |=> call_state == 10'h001) else $error("final drop wrong");
endmodule
bind fax_demod_endpoint_call_fsm fax_fsm_chk u_chk (.*);

// ### verification/v21_partner.sv
module v21_partner (
  input wire mclk,
  output logic msg_valid,
  output logic [5:0] msg_code,
  output logic msg_final,
  output logic msg_from_pkt,
  output logic [3:0] msg_rate,
  output logic [3:0] msg_kind,
  output logic rate_kind_ok,
  output logic demod_avail,
  output logic v21_arriving_chan,
  output logic v21_arriving_pkt,
  output logic ml_stop_confirm,
  output logic modlayer_abandon_confirm
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {msg_valid, msg_code, msg_final, msg_from_pkt, msg_rate, msg_kind, rate_kind_ok} = 18'h0;
    {v21_arriving_chan, v21_arriving_pkt, ml_stop_confirm, modlayer_abandon_confirm} = 4'h0;
    demod_avail = 1'b1;
  end
  // One-cycle strobe with all fields; fields flip afterwards so stale values are never trusted
  task send(input logic pk, input logic [5:0] c, input logic ok, input logic fin);
    msg_valid <= 1'b1;
    {msg_code, msg_from_pkt, msg_final, rate_kind_ok, msg_rate, msg_kind} <= {c, pk, fin, ok, 8'h52};
    @(posedge mclk);
    msg_valid <= 1'b0;
    {msg_code, msg_from_pkt, msg_final, rate_kind_ok, msg_rate, msg_kind} <= ~{c, pk, fin, ok, 8'h52};
  endtask
  task avail(input logic a);
    demod_avail <= a;
  endtask
  task pulse(input logic [1:0] w);
    {ml_stop_confirm, modlayer_abandon_confirm, v21_arriving_chan, v21_arriving_pkt} <= 4'h8 >> w;
    @(posedge mclk);
    {ml_stop_confirm, modlayer_abandon_confirm, v21_arriving_chan, v21_arriving_pkt} <= 4'h0;
  endtask
endmodule

// ### verification/tb.sv
`include "fax_demod_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0;
  logic nrst, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic msg_valid, msg_final, msg_from_pkt, rate_kind_ok, demod_avail, v21_arriving_chan, v21_arriving_pkt;
  logic ml_stop_confirm, modlayer_abandon_confirm, demod_remod_path, far_demod_remod_path, packet_voice_path;
  logic modlayer_begin_request, modlayer_halt_request, resource_alloc, resource_release;
  logic [5:0] msg_code;
  logic [3:0] msg_rate, msg_kind, begin_rate, begin_kind, stored_modem_rate, stored_modem_kind;
  logic [1:0] partial_page_retry_count;
  logic [9:0] call_state;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  // Row: side, code (0 = stop confirm), state after, retry count after
  logic [18:0] rows [22] = '{{1'b1, `MSG_DIS, 12'h008}, {1'b0, `MSG_DCS, 12'h020}, 19'h040, {1'b1, `MSG_CRP, 12'h008},
    {1'b0, `MSG_NSS, 12'h020}, 19'h040, {1'b1, `MSG_CFR, 12'h080}, 19'h100, {1'b0, `MSG_EOM, 12'h200},
    {1'b1, `MSG_RTN, 12'h008}, {1'b0, `MSG_DCS, 12'h020}, 19'h040, {1'b1, `MSG_CFR, 12'h080}, 19'h100,
    {1'b0, `MSG_MPS, 12'h200}, {1'b1, `MSG_PPR, 12'h081}, 19'h101, {1'b0, `MSG_MPS, 12'h201},
    {1'b1, `MSG_MCF, 12'h080}, 19'h100, {1'b0, `MSG_EOP, 12'h200}, {1'b1, `MSG_RTP, 12'h008}};
  always #4 mclk = ~mclk;
  fax_demod_endpoint_call_fsm #(.local_setup_cycles(20), .remote_setup_cycles(20), .confirm_cycles(20),
    .post_cmd_cycles(20), .post_resp_cycles(20), .command_cycles(20), .retx_cycles(20)) uut (.*);
  v21_partner p (.*);
  task conclude;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task msg(input logic pk, input logic [5:0] c, input logic ok, input logic fin);
    @(posedge mclk);
    p.send(pk, c, ok, fin);
    #1;
  endtask
  task ev(input logic [1:0] w);
    @(posedge mclk);
    p.pulse(w);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task page;
    msg(1, `MSG_DIS, 1, 0);
    msg(0, `MSG_DCS, 1, 0);
    ev(0);
    msg(1, `MSG_CFR, 1, 0);
  endtask
  task post(input logic [5:0] c);
    ev(0);
    msg(0, c, 1, 0);
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude;
    end
  end
  initial begin
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = 39'h0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    rd(4'h0, 32'h1);
    rd(4'h4, 32'h1);
    for (int i = 0; i < 22; i++) begin
      if (rows[i][17:12] == 6'h0) ev(0);
      else msg(rows[i][18], rows[i][17:12], 1, 0);
      chk(call_state, rows[i][11:2]);
      chk(demod_remod_path, rows[i][11:2] == 10'h008 || rows[i][11:2] == 10'h020);
      chk(partial_page_retry_count, rows[i][1:0]);
      chk({far_demod_remod_path, resource_alloc}, {1'b0, rows[i][17:12] == `MSG_DIS});
    end
    msg(0, `MSG_DCS, 0, 0);
    chk({call_state, resource_release}, {10'h001, 1'b1});
    msg(1, `MSG_DIS, 1, 0);
    msg(0, `MSG_NSC, 1, 0);
    chk(call_state, 10'h004);
    repeat (20) @(posedge mclk);
    #1;
    chk(call_state, 10'h004);
    @(posedge mclk);
    #1;
    chk(call_state, 10'h001);
    msg(1, `MSG_DIS, 1, 0);
    msg(0, `MSG_DCS, 1, 0);
    chk({modlayer_begin_request, stored_modem_rate, begin_kind}, 9'h152);
    rd(4'h4, 32'h00125008);
    ev(2);
    chk({call_state, modlayer_halt_request, packet_voice_path}, 12'h007);
    msg(1, `MSG_DIS, 1, 0);
    msg(0, `MSG_DCS, 1, 0);
    ev(1);
    chk({call_state, resource_release}, 11'h003);
    msg(1, `MSG_DIS, 1, 0);
    msg(0, `MSG_DCS, 1, 0);
    ev(0);
    msg(0, `MSG_NSS, 1, 0);
    chk(call_state, 10'h001);
    page;
    ev(3);
    chk({call_state, modlayer_halt_request, packet_voice_path}, 12'h007);
    page;
    post(`MSG_EOP);
    msg(1, `MSG_MCF, 1, 0);
    chk(call_state, 10'h001);
    page;
    for (int i = 1; i < 5; i++) begin
      post(`MSG_MPS);
      msg(1, `MSG_PPR, 1, 0);
      chk(partial_page_retry_count, i % 4);
    end
    chk(call_state, 10'h200);
    msg(1, `MSG_DCN, 1, 1);
    chk(call_state, 10'h001);
    page;
    post(`MSG_EOM);
    msg(1, `MSG_CRP, 1, 0);
    chk(call_state, 10'h080);
    msg(1, `MSG_PIP, 1, 0);
    chk(call_state, 10'h100);
    msg(0, `MSG_DIS, 1, 1);
    chk(call_state, 10'h001);
    page;
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk({call_state, demod_remod_path, stored_modem_rate}, {10'h001, 1'b0, 4'h0});
    wr(4'h0, 32'h0);
    msg(1, `MSG_DIS, 1, 0);
    chk(call_state, 10'h001);
    wr(4'h0, 32'h1);
    p.avail(1'b0);
    msg(1, `MSG_DIS, 1, 0);
    chk(call_state, 10'h001);
    p.avail(1'b1);
    wr(4'h4, 32'hffffffff);
    rd(4'h8, 32'h0);
    rd(4'h4, 32'h1);
    rd(4'h0, 32'h1);
    conclude;
  end
endmodule
